// [src/vga_access_trap_and_path.sv]
// Top of the VGA access trap, range detection and byte sequencer.
// Assumes the core presents physical addresses and memory acks reads.
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
module vga_access_trap_and_path
    import vatp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cpu_valid,
    input wire logic [19:0] cpu_addr,
    output logic smi_mem,
    input wire logic io_valid,
    input wire logic [9:0] io_addr,
    output logic smi_io,
    input wire logic xb_valid,
    input wire logic xb_write,
    input wire logic [19:0] xb_addr,
    input wire logic [1:0] xb_size,
    input wire logic [31:0] xb_wdata,
    output logic gp_hit,
    output logic xb_ready,
    output logic xb_done,
    output logic [31:0] xb_rdata,
    output logic smi_wr,
    output logic mem_req,
    output logic mem_we,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    output logic [3:0] mem_be,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata
);
    ////////////////////////////////////////////////////////////////////
    logic [2:0] range_ctl;
    logic [31:0] region_mask;
    logic [31:0] wr_ctl;
    logic [31:0] rd_ctl;
    logic [13:0] plane_base;
    logic [6:0] io_map;
    logic [31:0] latch;
    vatp_state_t state;
    vatp_state_t next_state;
    logic [19:0] acc_addr;
    logic [31:0] acc_data;
    logic acc_write;
    logic [1:0] cnt;
    logic [1:0] last;
    vatp_path_if pth ();
    vatp_write_path u_wp (.pth(pth));
    vatp_read_path u_rp (.pth(pth));

    ////////////////////////////////////////////////////////////////////
    // Register bus
    wire wr_en = psel & penable & pwrite;
    wire hit_rc = paddr == ADR_RANGE_CTL;
    wire hit_rm = paddr == ADR_REGION_MASK;
    wire hit_wc = paddr == ADR_WRITE_CTL;
    wire hit_rd = paddr == ADR_READ_CTL;
    wire hit_pb = paddr == ADR_PLANE_BASE;
    wire hit_io = paddr == ADR_IO_MAP;
    wire hit_lt = paddr == ADR_LATCH;
    wire mapped = hit_rc | hit_rm | hit_wc | hit_rd | hit_pb | hit_io
        | hit_lt;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata = hit_rc ? {29'h0, range_ctl} : // RULE4
        hit_rm ? region_mask :
        hit_wc ? wr_ctl :
        hit_rd ? rd_ctl :
        hit_pb ? {plane_base, 18'h0} :
        hit_io ? {25'h0, io_map} :
        hit_lt ? latch : 32'h0;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            range_ctl <= RST_RANGE_CTL; // RULE5
            region_mask <= RST_REGION_MASK;
            wr_ctl <= RST_WRITE_CTL;
            rd_ctl <= RST_READ_CTL;
            plane_base <= RST_PLANE_BASE;
            io_map <= RST_IO_MAP;
        end
        else if (wr_en)
        begin
            if (hit_rc)
                range_ctl <= pwdata[2:0]; // RULE4
            if (hit_rm)
                region_mask <= pwdata; // RULE2
            if (hit_wc)
                wr_ctl <= pwdata;
            if (hit_rd)
                rd_ctl <= pwdata;
            if (hit_pb)
                plane_base <= pwdata[31:PLANE_BASE_LSB]; // RULE16
            if (hit_io)
                io_map <= pwdata[6:0]; // RULE7
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Core side traps, same cycle as the access
    wire c_a = cpu_addr[19:16] == SEG_A;
    wire c_b0 = cpu_addr[19:15] == SEG_B0;
    wire c_b8 = cpu_addr[19:15] == SEG_B8;
    wire c_reg = region_mask[cpu_addr[15:11]]; // RULE3
    assign smi_mem = cpu_valid & ((c_a & range_ctl[0] & c_reg) // RULE1 RULE20
        | (c_b0 & range_ctl[1]) | (c_b8 & range_ctl[2])); // RULE6
    wire [5:0] io_blk = io_addr[9:4];
    assign smi_io = io_valid & ((io_blk == IO_3B & io_map[0]) // RULE7
        | (io_blk == IO_3C & io_map[1]) | (io_blk == IO_3D & io_map[2]));

    ////////////////////////////////////////////////////////////////////
    // Range detection for the pipeline
    wire x_a = xb_addr[19:16] == SEG_A;
    wire x_b0 = xb_addr[19:15] == SEG_B0;
    wire x_b8 = xb_addr[19:15] == SEG_B8;
    assign gp_hit = xb_valid & ((x_a & io_map[4]) | (x_b0 & io_map[5]) // RULE8
        | (x_b8 & io_map[6]));
    assign xb_ready = state == VATP_IDLE;
    wire take = xb_ready & gp_hit;
    wire x_shown = x_a ? region_mask[xb_addr[15:11]] : 1'b1;

    ////////////////////////////////////////////////////////////////////
    // Sequencer
    wire [1:0] lo = acc_addr[1:0] + cnt; // RULE11
    wire [19:0] byte_addr = {acc_addr[19:2], lo};
    wire [16:0] off = byte_addr[16:0];
    wire chain4 = rd_ctl[RC_CHAIN4];
    wire oddeven = rd_ctl[RC_ODDEVEN];
    wire [15:0] word = chain4 ? {1'b0, off[16:2]} : // RULE15
        oddeven ? off[16:1] : off[15:0];
    wire [3:0] mmask = wr_ctl[WC_MAPMASK +: 4];
    wire [3:0] pl_one = 4'h1 << lo;
    wire [3:0] pl_oe = lo[0] ? 4'hA : 4'h5;
    wire [3:0] planes = chain4 ? (mmask & pl_one) :
        oddeven ? (mmask & pl_oe) : mmask; // RULE13
    wire [31:0] rel_addr = {plane_base, word, 2'b00}; // RULE15 RULE16
    wire fin = mem_ack & (cnt == last);

    assign pth.host_byte = acc_data[8*cnt +: 8]; // RULE9
    assign pth.addr_lo = lo;
    assign pth.latch = latch;
    assign pth.wr_ctl = wr_ctl;
    assign pth.rd_ctl = rd_ctl;
    assign pth.plane_word = mem_rdata;
    assign mem_req = state == VATP_ACC;
    assign xb_done = state == VATP_DONE;

    always_comb
    begin
        case (state)
            VATP_IDLE: next_state = take ? VATP_PREP : VATP_IDLE;
            VATP_PREP: next_state = VATP_ACC;
            VATP_ACC: next_state = fin ? VATP_DONE :
                mem_ack ? VATP_PREP : VATP_ACC;
            VATP_DONE: next_state = VATP_IDLE;
            default: next_state = VATP_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= VATP_IDLE;
            acc_addr <= 20'h0;
            acc_data <= 32'h0;
            acc_write <= 1'b0;
            cnt <= 2'h0;
            last <= 2'h0;
            smi_wr <= 1'b0;
        end
        else
        begin
            state <= next_state;
            smi_wr <= take & xb_write & x_shown; // RULE12
            if (take)
            begin
                acc_addr <= xb_addr;
                acc_data <= xb_wdata;
                acc_write <= xb_write;
                cnt <= 2'h0;
                last <= xb_size == 2'h2 ? 2'h3 : {1'b0, xb_size[0]};
            end
            else if (state == VATP_ACC && mem_ack)
                cnt <= cnt + 2'h1; // RULE9 RULE10
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mem_we <= 1'b0;
            mem_addr <= 32'h0;
            mem_wdata <= 32'h0;
            mem_be <= 4'h0;
            latch <= 32'h0;
            xb_rdata <= 32'h0;
        end
        else
        begin
            if (state == VATP_PREP)
            begin
                mem_we <= acc_write;
                mem_addr <= rel_addr;
                mem_wdata <= pth.wr_word; // RULE13
                mem_be <= acc_write ? planes : 4'hF;
            end
            if (take)
                xb_rdata <= 32'h0;
            else if (state == VATP_ACC && mem_ack && !acc_write)
            begin
                latch <= mem_rdata;
                xb_rdata[8*cnt +: 8] <= pth.rd_byte; // RULE10 RULE14
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_take;
        take;
    endsequence
    sequence s_prep_acc;
        state == VATP_PREP ##1 mem_req;
    endsequence

    property p_reset_quiet;
        @(posedge pclk) $rose(presetn) |-> range_ctl == 3'h0 && !smi_mem;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) // RULE5
        else $error("range control not zero after reset");

    property p_mem_trap;
        @(posedge pclk) disable iff (!presetn)
        cpu_valid && c_a && range_ctl[0] && c_reg |-> smi_mem;
    endproperty
    a_mem_trap: assert property (p_mem_trap) // RULE1
        else $error("enabled region access did not trap");

    property p_no_range;
        @(posedge pclk) disable iff (!presetn)
        range_ctl == 3'h0 |-> !smi_mem;
    endproperty
    a_no_range: assert property (p_no_range) // RULE6
        else $error("trap with no range enabled");

    property p_region_off;
        @(posedge pclk) disable iff (!presetn)
        c_a && !region_mask[cpu_addr[15:11]] |-> !smi_mem;
    endproperty
    a_region_off: assert property (p_region_off) // RULE20
        else $error("masked region trapped");

    property p_io_trap;
        @(posedge pclk) disable iff (!presetn)
        io_valid && io_blk == IO_3C && io_map[1] |-> smi_io;
    endproperty
    a_io_trap: assert property (p_io_trap) // RULE7
        else $error("enabled io range did not trap");

    property p_wr_smi;
        @(posedge pclk) disable iff (!presetn)
        s_take ##0 (xb_write && x_shown) |=> smi_wr;
    endproperty
    a_wr_smi: assert property (p_wr_smi) // RULE12
        else $error("displayed write did not trap");

    property p_read_no_smi;
        @(posedge pclk) disable iff (!presetn)
        s_take ##0 !xb_write |=> !smi_wr;
    endproperty
    a_read_no_smi: assert property (p_read_no_smi) // RULE14
        else $error("read path raised a trap");

    property p_byte_seq;
        @(posedge pclk) disable iff (!presetn)
        s_take |=> s_prep_acc;
    endproperty
    a_byte_seq: assert property (p_byte_seq) // RULE9
        else $error("accepted access did not issue a byte op");

    property p_addr_lo;
        @(posedge pclk) disable iff (!presetn)
        s_prep_acc |-> mem_addr[1:0] == 2'b00
            && mem_addr[31:PLANE_BASE_LSB] == plane_base;
    endproperty
    a_addr_lo: assert property (p_addr_lo) // RULE16
        else $error("plane address not word aligned");
endmodule : vga_access_trap_and_path

// [src/vatp_pkg.sv]
// Constants, register map and types of the VGA access trap and path.
// Assumes an APB slave with 32-bit data and 12-bit byte addresses.
// Summary of operation
// RULE1 - Memory trap acts on physical addresses and fires in the same cycle.
// RULE2 - A 32-bit region mask holds one trap enable per 2 KB region.
// RULE3 - Mask bit n covers A0000h plus n times 2 KB; one enables.
// RULE4 - Range control bits 0..2 enable A, B0 and B8 segments; 7:3 reserved.
// RULE5 - Range control resets to zero so nothing traps after reset.
// RULE6 - With no range enabled the mask is ignored and no trap fires.
// RULE7 - I/O traps for 3B0h, 3C0h and 3D0h each have own enable.
// RULE8 - Range detection claims A0000h-BFFFFh per enabled sub-range.
// RULE9 - Wide writes are split into successive byte writes.
// RULE10 - Wide reads are assembled from successive byte reads.
// RULE11 - The sequencer generates the two low address bits itself.
// RULE12 - Path writes trap only when the location is displayed.
// RULE13 - Write path: rotate, ALU, bit mask, plane select/enable, write mode.
// RULE14 - Read path: color compare, plane select, read mode; never traps.
// RULE15 - Address generator relocates to plane memory base, odd/even, chain-4.
// RULE16 - Plane memory is 64K words of 32 bits on a 256 KB boundary.
// RULE17 - Software may leave memory traps off in direct colour modes.
// RULE18 - Read mode 0 with chain-4 picks the plane from address bits 1:0.
// RULE19 - Bit mask picks ALU output or latch per bit; zero picks latch.
// RULE20 - A segment traps only with range bit 0 and region bit set.
package vatp_pkg;
    localparam logic [9:0] IDX_RANGE_CTL = 10'h0B9;
    localparam logic [9:0] IDX_REGION_MASK = 10'h0BA;
    localparam logic [11:0] ADR_RANGE_CTL = {IDX_RANGE_CTL, 2'b00};
    localparam logic [11:0] ADR_REGION_MASK = {IDX_REGION_MASK, 2'b00};
    localparam logic [11:0] ADR_WRITE_CTL = 12'h300;
    localparam logic [11:0] ADR_READ_CTL = 12'h304;
    localparam logic [11:0] ADR_PLANE_BASE = 12'h308;
    localparam logic [11:0] ADR_IO_MAP = 12'h30C;
    localparam logic [11:0] ADR_LATCH = 12'h310;
    localparam logic [2:0] RST_RANGE_CTL = 3'h0;
    localparam logic [31:0] RST_REGION_MASK = 32'h00000000;
    localparam logic [31:0] RST_WRITE_CTL = 32'h0F0000FF;
    localparam logic [31:0] RST_READ_CTL = 32'h00000000;
    localparam logic [13:0] RST_PLANE_BASE = 14'h0000;
    localparam logic [6:0] RST_IO_MAP = 7'h00;
    localparam logic [3:0] SEG_A = 4'hA;
    localparam logic [4:0] SEG_B0 = 5'h16;
    localparam logic [4:0] SEG_B8 = 5'h17;
    localparam logic [5:0] IO_3B = 6'h3B;
    localparam logic [5:0] IO_3C = 6'h3C;
    localparam logic [5:0] IO_3D = 6'h3D;
    localparam int PLANE_BASE_LSB = 18;
    // Write control fields
    localparam int WC_BITMASK = 0;
    localparam int WC_SR = 8;
    localparam int WC_SRE = 12;
    localparam int WC_ROT = 16;
    localparam int WC_W2 = 19;
    localparam int WC_W3 = 20;
    localparam int WC_ALU = 21;
    localparam int WC_MAPMASK = 24;
    // Read control fields
    localparam int RC_CCOMP = 0;
    localparam int RC_CDC = 8;
    localparam int RC_RMS = 16;
    localparam int RC_RMODE1 = 20;
    localparam int RC_CHAIN4 = 21;
    localparam int RC_ODDEVEN = 22;
    typedef enum logic [1:0] {VATP_COPY, VATP_AND, VATP_OR, VATP_XOR}
        vatp_alu_t;
    typedef enum {VATP_IDLE, VATP_PREP, VATP_ACC, VATP_DONE} vatp_state_t;
endpackage : vatp_pkg

// [src/vatp_path_if.sv]
// Byte path bundle between the sequencer and the write and read paths.
// Assumes all three parties run on the same clock.
`timescale 1ns/1ps
interface vatp_path_if;
    logic [7:0] host_byte;
    logic [1:0] addr_lo;
    logic [31:0] latch;
    logic [31:0] wr_ctl;
    logic [31:0] rd_ctl;
    logic [31:0] plane_word;
    logic [31:0] wr_word;
    logic [7:0] rd_byte;
    modport seq (output host_byte, addr_lo, latch, wr_ctl, rd_ctl,
        plane_word, input wr_word, rd_byte);
    modport wp (input host_byte, latch, wr_ctl, output wr_word);
    modport rp (input addr_lo, plane_word, rd_ctl, output rd_byte);
endinterface : vatp_path_if

// [src/vatp_write_path.sv]
// Byte to plane word conversion for VGA writes.
// Assumes the latch holds the last plane word read.
`timescale 1ns/1ps
module vatp_write_path
    import vatp_pkg::*;
(
    vatp_path_if.wp pth
);
    wire [2:0] rot = pth.wr_ctl[WC_ROT +: 3];
    wire [15:0] dbl = {pth.host_byte, pth.host_byte};
    wire [15:0] shifted = dbl >> rot;
    wire [7:0] rdat = shifted[7:0];
    wire [3:0] sr = pth.wr_ctl[WC_SR +: 4];
    wire [3:0] sre = pth.wr_ctl[WC_SRE +: 4];
    wire w2 = pth.wr_ctl[WC_W2];
    wire w3 = pth.wr_ctl[WC_W3];
    wire [7:0] bmask = pth.wr_ctl[WC_BITMASK +: 8];
    wire [1:0] alu = pth.wr_ctl[WC_ALU +: 2];
    wire [7:0] eff_mask = w3 ? (bmask & rdat) : bmask;
    logic [31:0] mode_word;
    logic [31:0] alu_word;
    always_comb
    begin
        for (int b = 0; b < 4; b++)
        begin
            if (w3)
                mode_word[8*b +: 8] = {8{sr[b]}};
            else if (w2)
                mode_word[8*b +: 8] = {8{pth.host_byte[b]}};
            else
                mode_word[8*b +: 8] = sre[b] ? {8{sr[b]}} : rdat;
        end
    end
    always_comb
    begin
        case (vatp_alu_t'(alu))
            VATP_AND: alu_word = mode_word & pth.latch;
            VATP_OR: alu_word = mode_word | pth.latch;
            VATP_XOR: alu_word = mode_word ^ pth.latch;
            default: alu_word = mode_word;
        endcase
    end
    wire [31:0] sel = {4{eff_mask}};
    // One selects the ALU, zero the latch
    assign pth.wr_word = (alu_word & sel) | (pth.latch & ~sel); // RULE19 RULE13
endmodule : vatp_write_path

// [src/vatp_read_path.sv]
// Plane word to byte conversion for VGA reads.
// Assumes the plane word is the value just returned by memory.
`timescale 1ns/1ps
module vatp_read_path
    import vatp_pkg::*;
(
    vatp_path_if.rp pth
);
    wire [3:0] ccomp = pth.rd_ctl[RC_CCOMP +: 4];
    wire [3:0] cdc = pth.rd_ctl[RC_CDC +: 4];
    wire [1:0] rms = pth.rd_ctl[RC_RMS +: 2];
    wire chain4 = pth.rd_ctl[RC_CHAIN4];
    wire oddeven = pth.rd_ctl[RC_ODDEVEN];
    wire [1:0] plane = chain4 ? pth.addr_lo : // RULE18
        oddeven ? {rms[1], pth.addr_lo[0]} : rms;
    wire [7:0] mode0 = pth.plane_word[8*plane +: 8];
    logic [7:0] mode1;
    always_comb
    begin
        mode1 = 8'hFF;
        for (int b = 0; b < 4; b++)
        begin
            if (cdc[b])
                mode1 = mode1 & ~(pth.plane_word[8*b +: 8] ^ {8{ccomp[b]}});
        end
    end
    assign pth.rd_byte = pth.rd_ctl[RC_RMODE1] ? mode1 : mode0; // RULE14
endmodule : vatp_read_path

// [testbench/vatp_mem_model.sv]
// Graphics memory model behind the plane word port.
// Assumes one request at a time, held until acknowledged.
`timescale 1ns/1ps
module vatp_mem_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [3:0] wait_cycles,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    input wire logic [3:0] mem_be,
    output logic mem_ack,
    output logic [31:0] mem_rdata
);
    // Word store, 32 bits per plane word
    logic [31:0] mem [logic [31:0]];
    logic [3:0] cnt;
    logic [31:0] word;
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mem_ack <= 1'b0;
            mem_rdata <= 32'h5A5A5A5A;
            cnt <= 4'h0;
        end
        else if (mem_req && !mem_ack && cnt == wait_cycles)
        begin
            word = mem.exists(mem_addr) ? mem[mem_addr] : ~mem_addr;
            for (int b = 0; b < 4; b++)
                if (mem_we && mem_be[b])
                    word[8*b+:8] = mem_wdata[8*b+:8];
            mem[mem_addr] = word;
            mem_rdata <= word;
            mem_ack <= 1'b1;
            cnt <= 4'h0;
        end
        else
        begin
            // Idle data toggles so stale values are never reused
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            if (mem_req && !mem_ack)
                cnt <= cnt + 4'h1;
        end
    end
endmodule : vatp_mem_model

// [testbench/tb_vga_access_trap_and_path.sv]
// Self-checking bench for the VGA access trap and path.
// Assumes vatp_mem_model answers the plane memory port.
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
    begin \
        samples_checked++; \
        if ((got) !== (ex)) \
        begin \
            fail_count++; \
            $display("ERROR %s expected %h seen %h", nm, ex, got); \
        end \
    end
module tb_vga_access_trap_and_path import vatp_pkg::*;;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, xb_wdata, xb_rdata, mem_addr, mem_wdata;
    logic [31:0] mem_rdata, rd;
    logic cpu_valid, smi_mem, io_valid, smi_io, xb_valid, xb_write, gp_hit;
    logic xb_ready, xb_done, smi_wr, mem_req, mem_we, mem_ack, err, hit;
    logic [19:0] cpu_addr, xb_addr;
    logic [9:0] io_addr;
    logic [1:0] xb_size;
    logic [3:0] mem_be, wait_cycles;
    logic [67:0] wq[$];
    int fail_count, samples_checked, cycles, smi_wr_count;
    localparam logic [31:0] BASE = 32'h00C40000;
    localparam logic [19:0] SEG_LO [3] = '{20'hA0000, 20'hB0000, 20'hB8000};
    localparam logic [19:0] SEG_HI [3] = '{20'hAFFFF, 20'hB7FFF, 20'hBFFFF};
    localparam logic [9:0] IO_LO [3] = '{10'h3B0, 10'h3C0, 10'h3D0};

    vga_access_trap_and_path vga_access_trap_and_path_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cpu_valid(cpu_valid),
        .cpu_addr(cpu_addr), .smi_mem(smi_mem), .io_valid(io_valid),
        .io_addr(io_addr), .smi_io(smi_io), .xb_valid(xb_valid),
        .xb_write(xb_write), .xb_addr(xb_addr), .xb_size(xb_size),
        .xb_wdata(xb_wdata), .gp_hit(gp_hit), .xb_ready(xb_ready),
        .xb_done(xb_done), .xb_rdata(xb_rdata), .smi_wr(smi_wr),
        .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_be(mem_be), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata));
    vatp_mem_model vatp_mem_model_inst (
        .pclk(pclk), .presetn(presetn), .wait_cycles(wait_cycles),
        .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_be(mem_be), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata));

    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // Collect plane writes, count write traps, cut hangs short
    always @(posedge pclk)
    begin
        cycles++;
        if (mem_req && mem_ack && mem_we)
            wq.push_back({mem_be, mem_addr, mem_wdata});
        if (smi_wr === 1'b1)
            smi_wr_count++;
        if (cycles == 20000)
        begin
            fail_count++;
            summarize();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task summarize();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : summarize

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task probe(input logic [19:0] a, input logic [9:0] io);
        @(posedge pclk);
        cpu_valid <= 1'b1;
        io_valid <= 1'b1;
        cpu_addr <= a;
        io_addr <= io;
        #1;
    endtask : probe

    task xb(input logic w, input logic [1:0] sz, input logic [19:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        xb_valid <= 1'b1;
        xb_write <= w;
        xb_size <= sz;
        xb_addr <= a;
        xb_wdata <= d;
        @(posedge pclk);
        hit = gp_hit;
        if (hit === 1'b1)
        begin
            while (xb_ready !== 1'b1)
                @(posedge pclk);
            xb_valid <= 1'b0;
            do
                @(posedge pclk);
            while (xb_done !== 1'b1);
            @(posedge pclk);
            rd = xb_rdata;
        end
        xb_valid <= 1'b0;
    endtask : xb

    task wchk(input logic [15:0] off, input logic [31:0] wd,
        input logic [3:0] be);
        logic [67:0] seen;
        seen = wq.pop_front();
        `CHK("plane write", {be, BASE | {14'h0, off, 2'b00}, wd}, seen)
    endtask : wchk

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        {presetn, psel, penable, pwrite, cpu_valid, io_valid} = '0;
        {xb_valid, xb_write, xb_size, paddr, pwdata, cpu_addr} = '0;
        {io_addr, xb_addr, xb_wdata} = '0;
        wait_cycles = 4'h2;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ADR_RANGE_CTL, 32'h0);
        `CHK("range ctl reset", 32'h0, rd)
        apb(1'b0, 12'h100, 32'h0);
        `CHK("unmapped", 1'b1, err)
        apb(1'b1, ADR_RANGE_CTL, 32'hFF);
        apb(1'b0, ADR_RANGE_CTL, 32'h0);
        `CHK("reserved bits", 32'h7, rd)
        apb(1'b1, ADR_RANGE_CTL, 32'h0);
        apb(1'b1, ADR_REGION_MASK, 32'hFFFFFFFF);
        for (int j = 0; j < 3; j++)
        begin
            probe(SEG_LO[j], IO_LO[j]);
            `CHK("no range", 1'b0, smi_mem)
        end
        apb(1'b1, ADR_RANGE_CTL, 32'h1);
        for (int n = 0; n < 32; n++)
        begin
            apb(1'b1, ADR_REGION_MASK, 32'h1 << n);
            probe(20'hA0000 + 20'(n * 2048), 10'h0);
            `CHK("region lo", 1'b1, smi_mem)
            probe(20'hA07FF + 20'(n * 2048), 10'h0);
            `CHK("region hi", 1'b1, smi_mem)
            probe(20'hA0000 + 20'(((n + 1) % 32) * 2048), 10'h0);
            `CHK("region off", 1'b0, smi_mem)
        end
        apb(1'b1, ADR_REGION_MASK, 32'hFFFFFFFF);
        for (int k = 0; k < 3; k++)
        begin
            apb(1'b1, ADR_RANGE_CTL, 32'h1 << k);
            apb(1'b1, ADR_IO_MAP, 32'h11 << k);
            for (int j = 0; j < 3; j++)
            begin
                probe(SEG_LO[j], IO_LO[j]);
                `CHK("mem trap lo", j == k, smi_mem)
                `CHK("io trap lo", j == k, smi_io)
                probe(SEG_HI[j], IO_LO[j] + 10'hF);
                `CHK("mem trap hi", j == k, smi_mem)
                `CHK("io trap hi", j == k, smi_io)
                xb(1'b0, 2'd0, SEG_LO[j], 32'h0);
                `CHK("claim", j == k, hit)
            end
        end
        probe(20'hC0000, 10'h3E0);
        `CHK("outside", 2'b00, {smi_mem, smi_io})
        apb(1'b1, ADR_IO_MAP, 32'h70);
        apb(1'b1, ADR_RANGE_CTL, 32'h1);
        apb(1'b1, ADR_REGION_MASK, 32'h1);
        apb(1'b1, ADR_PLANE_BASE, BASE);
        smi_wr_count = 0;
        xb(1'b1, 2'd2, 20'hA0100, 32'h44332211);
        for (int i = 0; i < 4; i++)
            wchk(16'h100 + 16'(i), {4{8'(32'h44332211 >> 8 * i)}}, 4'hF);
        `CHK("displayed trap", 1, smi_wr_count)
        apb(1'b1, ADR_REGION_MASK, 32'h0);
        xb(1'b1, 2'd0, 20'hA0180, 32'h77);
        wchk(16'h180, 32'h77777777, 4'hF);
        `CHK("hidden write", 1, smi_wr_count)
        wait_cycles <= 4'h0;
        xb(1'b0, 2'd2, 20'hA0100, 32'h0);
        `CHK("wide read", 32'h44332211, rd)
        `CHK("read no trap", 1, smi_wr_count)
        vatp_mem_model_inst.mem[BASE | 32'h200] = 32'hD4C3B2A1;
        apb(1'b1, ADR_READ_CTL, 32'h1 << RC_CHAIN4);
        xb(1'b0, 2'd2, 20'hA0200, 32'h0);
        `CHK("chain4 read", 32'hD4C3B2A1, rd)
        xb(1'b0, 2'd1, 20'hA0202, 32'h0);
        `CHK("half read", 32'h0000D4C3, rd)
        apb(1'b0, ADR_LATCH, 32'h0);
        `CHK("latch", 32'hD4C3B2A1, rd)
        apb(1'b1, ADR_READ_CTL, 32'h0);
        apb(1'b1, ADR_WRITE_CTL, 32'h0500000F);
        xb(1'b1, 2'd0, 20'hA0300, 32'h5A);
        wchk(16'h300, 32'hDACABAAA, 4'h5);
        apb(1'b1, ADR_READ_CTL, 32'h00100F00);
        xb(1'b0, 2'd0, 20'hA0100, 32'h0);
        `CHK("color compare", 32'h000000EE, rd)
        apb(1'b1, ADR_READ_CTL, 32'h0);
        apb(1'b1, ADR_WRITE_CTL, 32'h0F6800FF);
        xb(1'b1, 2'd0, 20'hA0400, 32'h05);
        wchk(16'h400, 32'h11EE11EE, 4'hF);
        apb(1'b1, ADR_WRITE_CTL, 32'h0F0453FF);
        xb(1'b1, 2'd0, 20'hA0500, 32'h5A);
        wchk(16'h500, 32'hA500A5FF, 4'hF);
        summarize();
    end
endmodule : tb_vga_access_trap_and_path
